// file: port_cfg_pkg.sv
// Package with register map, reset values and carrier types for the port block.
package port_cfg_pkg;

	// -------------------------------------------------------------------
	// Register addresses
	// -------------------------------------------------------------------
	localparam logic [7:0] ADDR_PORT_ONE_LATCH = 8'h90;
	localparam logic [7:0] ADDR_PORT_TWO_LATCH = 8'hA0;
	localparam logic [7:0] ADDR_PORT_ONE_OUTPUT_MODE = 8'hA5;
	localparam logic [7:0] ADDR_PORT_TWO_OUTPUT_MODE = 8'hA6;
	localparam logic [7:0] ADDR_PORT_ONE_MATCH_MASK = 8'hBF;
	localparam logic [7:0] ADDR_PORT_ONE_MATCH_VALUE = 8'hCF;
	localparam logic [7:0] ADDR_PORT_ONE_CROSSBAR_SKIP = 8'hD5;
	localparam logic [7:0] ADDR_PORT_TWO_CROSSBAR_SKIP = 8'hD6;
	localparam logic [7:0] ADDR_PORT_ONE_INPUT_MODE = 8'hF2;
	localparam logic [7:0] ADDR_PORT_TWO_INPUT_MODE = 8'hF3;

	// -------------------------------------------------------------------
	// Reset values and field masks
	// -------------------------------------------------------------------
	localparam logic [7:0] RST_LATCH = 8'hFF;
	localparam logic [7:0] RST_OUTPUT_MODE = 8'h00;
	localparam logic [7:0] RST_MATCH_MASK = 8'h00;
	localparam logic [7:0] RST_MATCH_VALUE = 8'hFF;
	localparam logic [7:0] RST_SKIP = 8'h00;
	localparam logic [7:0] RST_INPUT_MODE = 8'hFF;
	localparam logic [7:0] PORT_TWO_OUTPUT_MODE_WMASK = 8'h01;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// -------------------------------------------------------------------
	// Carrier types
	// -------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] input_mode;
		logic [7:0] output_mode;
		logic [7:0] skip;
		logic [7:0] latch;
	} port_cfg_s;

	typedef struct packed {
		logic [7:0] drive_low;
		logic [7:0] drive_high;
		logic [7:0] pullup_en;
		logic [7:0] receiver_en;
	} pin_ctrl_s;

endpackage

// file: port_pin_config_match.sv
// Port pin configuration, latch, read path and match-event logic.
`timescale 1ns/10ps

// Operation
// - Analog pin disables pullup, digital driver and digital receiver.
// - Input-mode bit 0 is analog input, 1 is digital.
// - Output-mode bit is ignored when the pin is analog.
// - Output-mode 0 is open-drain, 1 is push-pull.
// - Skip bit 1 makes crossbar pass the pin over.
// - Match event when masked pins differ from masked match value.
// - Mask bit 0 excludes a pin from the comparison.
// - Latch drives only pins not assigned to peripherals by the crossbar.
// - Latch 0 drives low; 1 drives high or floats per mode.
// - Port read gives 0 for analog pins, live level for digital.
// - Read-modify-write reads the latch rather than the pins.
// - Match event requests interrupt when enabled and wakes the oscillator.
module port_pin_config_match (
	input wire logic MCLK, // System clock.
	input wire logic RST, // Synchronous reset, active high.
	input wire logic [7:0] SFR_ADDR, // Register address.
	input wire logic SFR_WR, // Write strobe.
	input wire logic [7:0] SFR_WDATA, // Write data.
	input wire logic SFR_RD, // Read strobe.
	input wire logic SFR_RMW, // Read returns latch, not pins.
	output logic [7:0] SFR_RDATA, // Registered read data.
	input wire logic [7:0] P1_PIN_IN, // Port one pin levels.
	input wire logic [7:0] P2_PIN_IN, // Port two pin levels.
	input wire logic [7:0] P1_XBAR_SEL, // Crossbar owns port one pin.
	input wire logic [7:0] P1_XBAR_OUT, // Peripheral level, port one.
	input wire logic [7:0] P2_XBAR_SEL, // Crossbar owns port two pin.
	input wire logic [7:0] P2_XBAR_OUT, // Peripheral level, port two.
	input wire logic MATCH_INT_EN, // Match interrupt enable.
	output logic [7:0] P1_PIN_OUT, // Port one drive level.
	output logic [7:0] P1_PIN_OE_N, // Port one enable, low drives.
	output logic [7:0] P1_PULLUP_EN, // Port one weak pullup on.
	output logic [7:0] P2_PIN_OUT, // Port two drive level.
	output logic [7:0] P2_PIN_OE_N, // Port two enable, low drives.
	output logic [7:0] P2_PULLUP_EN, // Port two weak pullup on.
	output logic [7:0] P1_SKIP, // Port one skip to crossbar.
	output logic [7:0] P2_SKIP, // Port two skip to crossbar.
	output logic MATCH_EVENT, // Port one match level.
	output logic MATCH_IRQ, // Match interrupt request.
	output logic WAKE_REQ // Oscillator wake request.
);

	// -------------------------------------------------------------------
	// Decoding helpers
	// -------------------------------------------------------------------
	// Pin levels reach the pad one cycle after the registered config they are decoded from.
	function automatic port_cfg_pkg::pin_ctrl_s pin_ctrl(
		input port_cfg_pkg::port_cfg_s cfg,
		input logic [7:0] xsel,
		input logic [7:0] xout
	);
		port_cfg_pkg::pin_ctrl_s r;
		logic [7:0] lvl;
		lvl = (xsel & ~cfg.skip & xout) | (~(xsel & ~cfg.skip) & cfg.latch);
		r.drive_low = cfg.input_mode & ~lvl;
		r.drive_high = cfg.input_mode & cfg.output_mode & lvl;
		r.pullup_en = cfg.input_mode & ~r.drive_low & ~r.drive_high;
		r.receiver_en = cfg.input_mode;
		return r;
	endfunction

	function automatic logic [7:0] pin_read(
		input logic [7:0] mode,
		input logic [7:0] lvl
	);
		return mode & lvl;
	endfunction

	// -------------------------------------------------------------------
	// Pin synchronisers
	// -------------------------------------------------------------------
	// Each pin passes three flops; a level is taken only when the last two
	// agree, so a pin caught mid-transition never reaches the match logic.
	// The taken levels reset low; the match mask resets to all excluded,
	// so the settling pins cannot raise a false match after reset.
	logic [7:0] p1_s1, p1_s2, p1_s3, p2_s1, p2_s2, p2_s3;
	logic [7:0] p1_lvl, p2_lvl;
	logic [7:0] next_p1_lvl, next_p2_lvl;

	always_comb begin
		next_p1_lvl = p1_lvl;
		next_p2_lvl = p2_lvl;
		for (int i = 0; i < 8; i++) begin
			if (p1_s2[i] == p1_s3[i]) begin
				next_p1_lvl[i] = p1_s3[i];
			end
			if (p2_s2[i] == p2_s3[i]) begin
				next_p2_lvl[i] = p2_s3[i];
			end
		end
	end

	always_ff @(posedge MCLK) begin
		p1_s1 <= P1_PIN_IN;
		p1_s2 <= p1_s1;
		p1_s3 <= p1_s2;
		p2_s1 <= P2_PIN_IN;
		p2_s2 <= p2_s1;
		p2_s3 <= p2_s2;
		if (RST) begin
			p1_lvl <= port_cfg_pkg::ZERO_BYTE;
			p2_lvl <= port_cfg_pkg::ZERO_BYTE;
		end else begin
			p1_lvl <= next_p1_lvl;
			p2_lvl <= next_p2_lvl;
		end
	end

	// -------------------------------------------------------------------
	// Registers
	// -------------------------------------------------------------------
	port_cfg_pkg::port_cfg_s cfg1, cfg2, next_cfg1, next_cfg2;
	logic [7:0] match_mask, match_value, next_match_mask, next_match_value;
	logic [7:0] next_rdata;

	always_comb begin
		next_cfg1 = cfg1;
		next_cfg2 = cfg2;
		next_match_mask = match_mask;
		next_match_value = match_value;
		next_rdata = SFR_RDATA;
		if (SFR_WR) begin
			case (SFR_ADDR)
				port_cfg_pkg::ADDR_PORT_ONE_LATCH: next_cfg1.latch = SFR_WDATA;
				port_cfg_pkg::ADDR_PORT_TWO_LATCH: next_cfg2.latch = SFR_WDATA;
				port_cfg_pkg::ADDR_PORT_ONE_OUTPUT_MODE:
					next_cfg1.output_mode = SFR_WDATA;
				port_cfg_pkg::ADDR_PORT_TWO_OUTPUT_MODE:
					next_cfg2.output_mode = SFR_WDATA
						& port_cfg_pkg::PORT_TWO_OUTPUT_MODE_WMASK;
				port_cfg_pkg::ADDR_PORT_ONE_MATCH_MASK: next_match_mask = SFR_WDATA;
				port_cfg_pkg::ADDR_PORT_ONE_MATCH_VALUE: next_match_value = SFR_WDATA;
				port_cfg_pkg::ADDR_PORT_ONE_CROSSBAR_SKIP: next_cfg1.skip = SFR_WDATA;
				port_cfg_pkg::ADDR_PORT_TWO_CROSSBAR_SKIP: next_cfg2.skip = SFR_WDATA;
				port_cfg_pkg::ADDR_PORT_ONE_INPUT_MODE:
					next_cfg1.input_mode = SFR_WDATA;
				port_cfg_pkg::ADDR_PORT_TWO_INPUT_MODE:
					next_cfg2.input_mode = SFR_WDATA;
				default: next_rdata = SFR_RDATA;
			endcase
		end
		if (SFR_RD) begin
			case (SFR_ADDR)
				port_cfg_pkg::ADDR_PORT_ONE_LATCH: next_rdata = SFR_RMW ? cfg1.latch
					: pin_read(cfg1.input_mode, p1_lvl);
				port_cfg_pkg::ADDR_PORT_TWO_LATCH: next_rdata = SFR_RMW ? cfg2.latch
					: pin_read(cfg2.input_mode, p2_lvl);
				port_cfg_pkg::ADDR_PORT_ONE_OUTPUT_MODE: next_rdata = cfg1.output_mode;
				port_cfg_pkg::ADDR_PORT_TWO_OUTPUT_MODE: next_rdata = cfg2.output_mode;
				port_cfg_pkg::ADDR_PORT_ONE_MATCH_MASK: next_rdata = match_mask;
				port_cfg_pkg::ADDR_PORT_ONE_MATCH_VALUE: next_rdata = match_value;
				port_cfg_pkg::ADDR_PORT_ONE_CROSSBAR_SKIP: next_rdata = cfg1.skip;
				port_cfg_pkg::ADDR_PORT_TWO_CROSSBAR_SKIP: next_rdata = cfg2.skip;
				port_cfg_pkg::ADDR_PORT_ONE_INPUT_MODE: next_rdata = cfg1.input_mode;
				port_cfg_pkg::ADDR_PORT_TWO_INPUT_MODE: next_rdata = cfg2.input_mode;
				default: next_rdata = port_cfg_pkg::ZERO_BYTE;
			endcase
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			cfg1 <= '{port_cfg_pkg::RST_INPUT_MODE, port_cfg_pkg::RST_OUTPUT_MODE,
				port_cfg_pkg::RST_SKIP, port_cfg_pkg::RST_LATCH};
			cfg2 <= '{port_cfg_pkg::RST_INPUT_MODE, port_cfg_pkg::RST_OUTPUT_MODE,
				port_cfg_pkg::RST_SKIP, port_cfg_pkg::RST_LATCH};
			match_mask <= port_cfg_pkg::RST_MATCH_MASK;
			match_value <= port_cfg_pkg::RST_MATCH_VALUE;
			SFR_RDATA <= port_cfg_pkg::ZERO_BYTE;
		end else begin
			cfg1 <= next_cfg1;
			cfg2 <= next_cfg2;
			match_mask <= next_match_mask;
			match_value <= next_match_value;
			SFR_RDATA <= next_rdata;
		end
	end

	// -------------------------------------------------------------------
	// Pad control and match outputs
	// -------------------------------------------------------------------
	port_cfg_pkg::pin_ctrl_s c1, c2;
	logic next_match;

	always_comb begin
		c1 = pin_ctrl(cfg1, P1_XBAR_SEL, P1_XBAR_OUT);
		c2 = pin_ctrl(cfg2, P2_XBAR_SEL, P2_XBAR_OUT);
		next_match = (pin_read(cfg1.input_mode, p1_lvl) & match_mask)
			!= (match_value & match_mask);
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			P1_PIN_OUT <= port_cfg_pkg::ZERO_BYTE;
			P1_PIN_OE_N <= ~port_cfg_pkg::ZERO_BYTE;
			P1_PULLUP_EN <= port_cfg_pkg::ZERO_BYTE;
			P2_PIN_OUT <= port_cfg_pkg::ZERO_BYTE;
			P2_PIN_OE_N <= ~port_cfg_pkg::ZERO_BYTE;
			P2_PULLUP_EN <= port_cfg_pkg::ZERO_BYTE;
			P1_SKIP <= port_cfg_pkg::RST_SKIP;
			P2_SKIP <= port_cfg_pkg::RST_SKIP;
			MATCH_EVENT <= 1'b0;
			MATCH_IRQ <= 1'b0;
			WAKE_REQ <= 1'b0;
		end else begin
			P1_PIN_OUT <= c1.drive_high;
			P1_PIN_OE_N <= ~(c1.drive_low | c1.drive_high);
			P1_PULLUP_EN <= c1.pullup_en;
			P2_PIN_OUT <= c2.drive_high;
			P2_PIN_OE_N <= ~(c2.drive_low | c2.drive_high);
			P2_PULLUP_EN <= c2.pullup_en;
			P1_SKIP <= cfg1.skip;
			P2_SKIP <= cfg2.skip;
			MATCH_EVENT <= next_match;
			MATCH_IRQ <= next_match & MATCH_INT_EN;
			WAKE_REQ <= next_match;
		end
	end

	// -------------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------------
	analog_no_drive_a: assert property (@(posedge MCLK) disable iff (RST)
		!$past(cfg1.input_mode[1]) && !$past(RST) |-> P1_PIN_OE_N[1] && !P1_PULLUP_EN[1])
		else $error("Analog pin still driven or pulled up.");
	pushpull_high_a: assert property (@(posedge MCLK) disable iff (RST)
		$past(cfg2.input_mode[0] && cfg2.output_mode[0] && cfg2.latch[0]
		&& !P2_XBAR_SEL[0]) && !$past(RST) |-> !P2_PIN_OE_N[0] && P2_PIN_OUT[0])
		else $error("Push-pull high not driven.");
	latch_low_a: assert property (@(posedge MCLK) disable iff (RST)
		$past(cfg1.input_mode[1] && !cfg1.latch[1] && !P1_XBAR_SEL[1])
		&& !$past(RST) |-> !P1_PIN_OE_N[1] && !P1_PIN_OUT[1])
		else $error("Latch zero not driven low.");
	match_level_a: assert property (@(posedge MCLK) disable iff (RST)
		##1 $past(match_mask == port_cfg_pkg::ZERO_BYTE) |-> !MATCH_EVENT)
		else $error("Match raised with all pins masked.");
	irq_gate_a: assert property (@(posedge MCLK) disable iff (RST)
		MATCH_IRQ |-> MATCH_EVENT && WAKE_REQ)
		else $error("Interrupt without match.");
	rmw_latch_a: assert property (@(posedge MCLK) disable iff (RST)
		SFR_RD && SFR_RMW && SFR_ADDR == port_cfg_pkg::ADDR_PORT_TWO_LATCH
		|=> SFR_RDATA == $past(cfg2.latch))
		else $error("Read-modify-write did not return latch.");
	analog_read_a: assert property (@(posedge MCLK) disable iff (RST)
		SFR_RD && !SFR_RMW && SFR_ADDR == port_cfg_pkg::ADDR_PORT_ONE_LATCH
		&& !cfg1.input_mode[1] |=> !SFR_RDATA[1])
		else $error("Analog pin read as nonzero.");
	skip_out_a: assert property (@(posedge MCLK) disable iff (RST)
		SFR_WR && SFR_ADDR == port_cfg_pkg::ADDR_PORT_ONE_CROSSBAR_SKIP
		&& !SFR_RD |=> ##1 P1_SKIP == $past(SFR_WDATA, 2))
		else $error("Skip write not presented to crossbar.");

	// -------------------------------------------------------------------
	// Pad, read and match checks
	// -------------------------------------------------------------------
	// Pad outputs are registered, so each pad check looks at the configuration
	// one cycle earlier than the pad value it judges.
	open_drain_float_a: assert property (@(posedge MCLK) disable iff (RST)
		$past(cfg1.input_mode[0] && !cfg1.output_mode[0] && cfg1.latch[0]
		&& !P1_XBAR_SEL[0]) && !$past(RST) |-> P1_PIN_OE_N[0] && P1_PULLUP_EN[0])
		else $error("Open-drain high not released to pullup.");
	analog_mode_ignored_a: assert property (@(posedge MCLK) disable iff (RST)
		!$past(cfg2.input_mode[7]) && !$past(RST) |-> P2_PIN_OE_N[7] && !P2_PULLUP_EN[7])
		else $error("Analog pin followed its output mode.");
	xbar_route_a: assert property (@(posedge MCLK) disable iff (RST)
		$past(cfg2.input_mode[0] && P2_XBAR_SEL[0] && !cfg2.skip[0]
		&& !P2_XBAR_OUT[0]) && !$past(RST) |-> !P2_PIN_OE_N[0] && !P2_PIN_OUT[0])
		else $error("Crossbar-owned pin did not follow peripheral.");
	skip_pass_a: assert property (@(posedge MCLK) disable iff (RST)
		$past(cfg2.skip[0] && P2_XBAR_SEL[0] && cfg2.input_mode[0]
		&& cfg2.output_mode[0] && cfg2.latch[0]) && !$past(RST)
		|-> !P2_PIN_OE_N[0] && P2_PIN_OUT[0])
		else $error("Skipped pin did not follow its latch.");
	irq_follow_a: assert property (@(posedge MCLK) disable iff (RST)
		$past(MATCH_INT_EN) && MATCH_EVENT && !$past(RST) |-> MATCH_IRQ && WAKE_REQ)
		else $error("Enabled match raised no interrupt.");
	mode_readonly_a: assert property (@(posedge MCLK) disable iff (RST)
		(cfg2.output_mode & ~port_cfg_pkg::PORT_TWO_OUTPUT_MODE_WMASK)
		== port_cfg_pkg::ZERO_BYTE)
		else $error("Read-only output-mode bit was set.");
	digital_read_a: assert property (@(posedge MCLK) disable iff (RST)
		SFR_RD && !SFR_RMW && SFR_ADDR == port_cfg_pkg::ADDR_PORT_TWO_LATCH
		&& cfg2.input_mode[1] |=> SFR_RDATA[1] == $past(p2_lvl[1]))
		else $error("Digital pin read did not return its level.");
	pullup_digital_a: assert property (@(posedge MCLK) disable iff (RST)
		!$past(RST) |-> (P2_PULLUP_EN & ~$past(cfg2.input_mode))
		== port_cfg_pkg::ZERO_BYTE)
		else $error("Pullup on while pin is analog.");
	od_never_high_a: assert property (@(posedge MCLK) disable iff (RST)
		!$past(RST) |-> (P1_PIN_OUT & ~$past(cfg1.output_mode))
		== port_cfg_pkg::ZERO_BYTE)
		else $error("Open-drain pin driven high.");

endmodule // port_pin_config_match

// file: pad_world.sv
// Pad model that resolves port pin levels from every driver on the pins.
`timescale 1ns/10ps
module pad_world (
	input wire logic clk, // Clock for the float pattern.
	input wire logic [7:0] drv, // Device drive level.
	input wire logic [7:0] oe_n, // Low while the device drives.
	input wire logic [7:0] pull, // Weak pullup on.
	input wire logic [7:0] ext_val, // Outside drive level.
	input wire logic [7:0] ext_en, // Outside source drives.
	output logic [7:0] lvl // Resolved pin level.
);
	logic flt = 1'b0;
	always @(posedge clk) begin
		flt <= ~flt;
	end
	// Undriven pins without a pullup wander each cycle.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			lvl[i] = !oe_n[i] ? drv[i] : ext_en[i] ? ext_val[i] :
				pull[i] ? 1'b1 : flt;
		end
	end
endmodule // pad_world

// file: testbench.sv
// Self-checking testbench for the port configuration and match block.
`timescale 1ns/10ps
module testbench;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic rmw = 1'b0;
	logic [7:0] x2sel = 8'h00;
	logic [7:0] x2out = 8'h00;
	logic [7:0] e1v = 8'h00;
	logic [7:0] e1e = 8'h00;
	logic mie = 1'b0;
	logic [7:0] rdata, p1_in, p2_in, p1_out, p1_oen, p1_pu;
	logic [7:0] p2_out, p2_oen, p2_pu, p2_skip, p1_skip;
	logic mev, mirq, wake;
	int fail_count = 0;
	int compares = 0;
	logic [7:0] ra [9] = '{8'hA5, 8'hA6, 8'hBF, 8'hCF, 8'hD5, 8'hD6,
		8'hF2, 8'hF3, 8'hA0};
	logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00,
		8'hFF, 8'hFF, 8'hFF};
	always #4 mclk = ~mclk;
	port_pin_config_match i_port_pin_config_match (.MCLK(mclk), .RST(rst),
		.SFR_ADDR(addr), .SFR_WR(sfr_wr), .SFR_WDATA(wdata),
		.SFR_RD(sfr_rd), .SFR_RMW(rmw), .SFR_RDATA(rdata),
		.P1_PIN_IN(p1_in), .P2_PIN_IN(p2_in), .P1_XBAR_SEL(8'h00),
		.P1_XBAR_OUT(8'h00), .P2_XBAR_SEL(x2sel), .P2_XBAR_OUT(x2out),
		.MATCH_INT_EN(mie), .P1_PIN_OUT(p1_out), .P1_PIN_OE_N(p1_oen),
		.P1_PULLUP_EN(p1_pu), .P2_PIN_OUT(p2_out), .P2_PIN_OE_N(p2_oen),
		.P2_PULLUP_EN(p2_pu), .P1_SKIP(p1_skip), .P2_SKIP(p2_skip),
		.MATCH_EVENT(mev), .MATCH_IRQ(mirq), .WAKE_REQ(wake));
	pad_world i_pad_one (.clk(mclk), .drv(p1_out), .oe_n(p1_oen),
		.pull(p1_pu), .ext_val(e1v), .ext_en(e1e), .lvl(p1_in));
	pad_world i_pad_two (.clk(mclk), .drv(p2_out), .oe_n(p2_oen),
		.pull(p2_pu), .ext_val(8'h00), .ext_en(8'h00), .lvl(p2_in));
	// --------------------
	// Access tasks
	// --------------------
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		addr = a;
		wdata = d;
		sfr_wr = 1'b1;
		@(negedge mclk);
		sfr_wr = 1'b0;
	endtask
	task rdc(input logic [7:0] a, input logic m, input logic [7:0] exp);
		@(negedge mclk);
		addr = a;
		rmw = m;
		sfr_rd = 1'b1;
		@(negedge mclk);
		sfr_rd = 1'b0;
		rmw = 1'b0;
		chk(rdata, exp);
	endtask
	task test_done;
		if (fail_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#20000;
		fail_count++;
		test_done;
	end
	initial begin
		repeat (5) @(negedge mclk);
		rst = 1'b0;
		for (int i = 0; i < 9; i++) begin
			rdc(ra[i], 1'b1, rv[i]);
		end
		wr(8'hA6, 8'hFF);
		rdc(8'hA6, 1'b0, 8'h01);
		rdc(8'h77, 1'b0, 8'h00);
		wr(8'hF3, 8'h7F);
		wr(8'hD6, 8'h80);
		wr(8'hA0, 8'hF1);
		repeat (6) @(negedge mclk);
		chk(p2_oen, 8'hF0);
		chk(p2_out & ~p2_oen, 8'h01);
		chk(p2_pu, 8'h70);
		chk(p2_skip, 8'h80);
		rdc(8'hA0, 1'b0, 8'h71);
		rdc(8'hA0, 1'b1, 8'hF1);
		x2sel = 8'h01;
		repeat (3) @(negedge mclk);
		chk(p2_out & ~p2_oen, 8'h00);
		wr(8'hD6, 8'h81);
		repeat (3) @(negedge mclk);
		chk(p2_out & ~p2_oen, 8'h01);
		wr(8'hA5, 8'h5A);
		wr(8'hF2, 8'hFD);
		wr(8'hBF, 8'h05);
		wr(8'hCF, 8'h05);
		wr(8'hD5, 8'h3C);
		e1e = 8'hF0;
		mie = 1'b1;
		repeat (8) @(negedge mclk);
		chk(p1_oen, 8'hA7);
		chk(p1_skip, 8'h3C);
		chk(mev, 1'b0);
		rdc(8'h90, 1'b0, 8'h5D);
		e1e = 8'hF1;
		repeat (8) @(negedge mclk);
		chk(mev, 1'b1);
		chk(mirq, 1'b1);
		chk(wake, 1'b1);
		mie = 1'b0;
		repeat (2) @(negedge mclk);
		chk(mirq, 1'b0);
		test_done;
	end
endmodule // testbench
